// [logic/sepi_eeprom_dev.sv]
// Serial EEPROM device end: pin front end, command decode, array and protection
`timescale 1ns/1ps
// Contract
// - Select high enables serial traffic
// - Select rise restarts command state machine
// - Select fall launches programming after writes
// - Deselected device ignores clock and data
// - Input bit sampled on serial clock rise
// - Output bit changes on serial clock rise
// - Master shifts all fields in serially
// - Output driven only while selected
// - Protect select picks array or protect register
// - Writes need write_permit high
// - Master keeps select low minimum time
// - Leading zeros skipped until start bit
// - Start, opcode, address, data, MSB first
// - Read: dummy zero, word, auto-increment wrapping
// - Powers up locked; enable/disable commands
module sepi_eeprom_dev #(
	parameter int PROG_CYC = sepi_pkg::SEPI_PROG_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	sepi_link_if.dev link,
	output logic progBusy,
	output logic write_lock_state
);
	import sepi_pkg::*;

	// Two-stage synchronisers for the five pins
	logic [4:0] pinMeta_q;
	logic [4:0] pinSync_q;
	logic selPrev_q;
	logic skPrev_q;
	logic selS;
	logic skS;
	logic diS;
	logic preS;
	logic peS;
	logic selFall;
	logic selRise;
	logic skRise;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 5'h00;
			pinSync_q <= 5'h00;
			selPrev_q <= 1'b0;
			skPrev_q <= 1'b0;
		end else if (clkEn) begin
			pinMeta_q <= {link.devSelect, link.serial_clock, link.serial_in, link.protSel,
				link.write_permit};
			pinSync_q <= pinMeta_q;
			selPrev_q <= pinSync_q[4];
			skPrev_q <= pinSync_q[3];
		end
	end

	assign {selS, skS, diS, preS, peS} = pinSync_q;
	assign selRise = selS & ~selPrev_q;
	assign selFall = ~selS & selPrev_q;
	// Clock edges count only while selected
	assign skRise = skS & ~skPrev_q & selS;

	// Command state, shifters, protection and lock
	sepi_dev_state_t state_q, state_d;
	sepi_act_t pend_q, pend_d;
	logic [4:0] cnt_q, cnt_d;
	logic [15:0] shIn_q, shIn_d;
	logic [15:0] shOut_q, shOut_d;
	logic [5:0] ptr_q, ptr_d;
	logic allFlag_q, allFlag_d;
	logic outBit_q, outBit_d;
	logic outEn_q, outEn_d;
	logic unlocked_q, unlocked_d;
	logic [5:0] protAddr_q, protAddr_d;
	logic protValid_q, protValid_d;
	logic protArm_q, protArm_d;
	logic [SEPI_PROG_W-1:0] prog_q, prog_d;
	logic [15:0] mem [SEPI_WORDS];
	logic memWe;
	logic memAll;
	logic [7:0] hdr;
	logic [15:0] rdWord;
	logic isProt;

	assign hdr = {shIn_q[6:0], diS};
	// Protect register reads back as its first protected address
	assign rdWord = preS ? {10'h000, protAddr_q} : mem[hdr[5:0]];
	assign isProt = protValid_q && (ptr_q >= protAddr_q);

	always_comb begin
		state_d = state_q;
		pend_d = pend_q;
		cnt_d = cnt_q;
		shIn_d = shIn_q;
		shOut_d = shOut_q;
		ptr_d = ptr_q;
		allFlag_d = allFlag_q;
		outBit_d = outBit_q;
		outEn_d = selS;
		unlocked_d = unlocked_q;
		protAddr_d = protAddr_q;
		protValid_d = protValid_q;
		protArm_d = protArm_q;
		prog_d = prog_q;
		memWe = 1'b0;
		memAll = 1'b0;
		if (prog_q != '0) begin
			prog_d = prog_q - 1'b1;
		end
		// Deselected: pins ignored, counter, input shifter and output bit cleared
		if (!selS) begin
			state_d = SEPI_D_IDLE;
			cnt_d = 5'h00;
			shIn_d = 16'h0000;
			outBit_d = 1'b0;
		end
		// Fresh selection restarts decode; busy device ignores the cycle
		if (selRise) begin
			state_d = (prog_q != '0) ? SEPI_D_DONE : SEPI_D_IDLE;
			pend_d = SEPI_A_NONE;
		end
		// End of cycle carries out the shifted-in command
		if (selFall) begin
			pend_d = SEPI_A_NONE;
			case (pend_q)
				SEPI_A_WEN: unlocked_d = 1'b1;
				SEPI_A_WDS: unlocked_d = 1'b0;
				SEPI_A_WR: begin
					if (unlocked_q && peS && !isProt) begin
						memWe = 1'b1;
						prog_d = SEPI_PROG_W'(PROG_CYC);
					end
				end
				SEPI_A_WRALL: begin
					if (unlocked_q && peS && !protValid_q) begin
						memWe = 1'b1;
						memAll = 1'b1;
						prog_d = SEPI_PROG_W'(PROG_CYC);
					end
				end
				SEPI_A_PREN: protArm_d = unlocked_q && peS;
				SEPI_A_PRWR: begin
					if (unlocked_q && peS && protArm_q) begin
						protAddr_d = ptr_q;
						protValid_d = 1'b1;
						protArm_d = 1'b0;
						prog_d = SEPI_PROG_W'(PROG_CYC);
					end
				end
				SEPI_A_PRCLR: begin
					if (unlocked_q && peS && protArm_q) begin
						protValid_d = 1'b0;
						protAddr_d = SEPI_ADDR_ONES;
						protArm_d = 1'b0;
						prog_d = SEPI_PROG_W'(PROG_CYC);
					end
				end
				default: ;
			endcase
		end
		// Serial bit engine, one step per qualified clock rise
		if (skRise) begin
			case (state_q)
				SEPI_D_IDLE: begin
					if (diS) begin
						state_d = SEPI_D_HDR;
						cnt_d = 5'h00;
					end
				end
				SEPI_D_HDR: begin
					shIn_d = {shIn_q[14:0], diS};
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == 5'h07) begin
						ptr_d = hdr[5:0];
						cnt_d = 5'h00;
						state_d = SEPI_D_DONE;
						case (hdr[7:6])
							SEPI_OP_READ: begin
								shOut_d = rdWord;
								outBit_d = 1'b0;
								state_d = SEPI_D_READ;
							end
							SEPI_OP_WRITE: begin
								if (preS) begin
									pend_d = SEPI_A_PRWR;
								end else begin
									allFlag_d = 1'b0;
									state_d = SEPI_D_DATA;
								end
							end
							SEPI_OP_CLEAR: begin
								if (preS && hdr[5:0] == SEPI_ADDR_ONES) begin
									pend_d = SEPI_A_PRCLR;
								end
							end
							default: begin
								if (hdr[5:4] == SEPI_SUB_ON) begin
									pend_d = preS ? SEPI_A_PREN : SEPI_A_WEN;
								end else if (hdr[5:4] == SEPI_SUB_ALL && !preS) begin
									allFlag_d = 1'b1;
									state_d = SEPI_D_DATA;
								end else if (hdr[5:4] == SEPI_SUB_OFF && !preS) begin
									pend_d = SEPI_A_WDS;
								end
							end
						endcase
					end
				end
				SEPI_D_DATA: begin
					shIn_d = {shIn_q[14:0], diS};
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == 5'h0F) begin
						pend_d = allFlag_q ? SEPI_A_WRALL : SEPI_A_WR;
						state_d = SEPI_D_DONE;
					end
				end
				SEPI_D_READ: begin
					outBit_d = shOut_q[15];
					shOut_d = {shOut_q[14:0], 1'b0};
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == 5'h0F) begin
						ptr_d = ptr_q + 1'b1; // wraps 63 to 0
						shOut_d = preS ? {10'h000, protAddr_q} : mem[ptr_q + 1'b1];
						cnt_d = 5'h00;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= SEPI_D_IDLE;
			pend_q <= SEPI_A_NONE;
			cnt_q <= 5'h00;
			shIn_q <= SEPI_RST_WORD;
			shOut_q <= SEPI_RST_WORD;
			ptr_q <= SEPI_ADDR_ZERO;
			allFlag_q <= 1'b0;
			outBit_q <= 1'b0;
			outEn_q <= 1'b0;
			unlocked_q <= 1'b0;
			protAddr_q <= SEPI_RST_PROT_ADDR;
			protValid_q <= 1'b0;
			protArm_q <= 1'b0;
			prog_q <= '0;
		end else if (clkEn) begin
			state_q <= state_d;
			pend_q <= pend_d;
			cnt_q <= cnt_d;
			shIn_q <= shIn_d;
			shOut_q <= shOut_d;
			ptr_q <= ptr_d;
			allFlag_q <= allFlag_d;
			outBit_q <= outBit_d;
			outEn_q <= outEn_d;
			unlocked_q <= unlocked_d;
			protAddr_q <= protAddr_d;
			protValid_q <= protValid_d;
			protArm_q <= protArm_d;
			prog_q <= prog_d;
		end
	end

	// Array cells; contents are not reset, like the real cells
	for (genvar i = 0; i < SEPI_WORDS; i++) begin : g_cell
		always_ff @(posedge ref_clk) begin
			if (clkEn && memWe && (memAll || ptr_q == 6'(i))) begin
				mem[i] <= shIn_q;
			end
		end
	end

	assign link.serialOut = outBit_q;
	assign link.serialOutEn = outEn_q;
	assign write_lock_state = ~unlocked_q;
	assign progBusy = (prog_q != '0);
endmodule // sepi_eeprom_dev

// [logic/sepi_pkg.sv]
// Shared constants and types for the serial EEPROM pin link
package sepi_pkg;
	// Clock rate of ref_clk
	localparam int SEPI_CLK_MHZ = 200;
	// Link timing, figures in ns, cycle counts round up
	localparam int SEPI_SK_HALF_NS = 1000;
	localparam int SEPI_SK_HALF_CYC = (SEPI_SK_HALF_NS * SEPI_CLK_MHZ + 999) / 1000;
	localparam int SEPI_DESELECT_MIN_TIME_NS = 1000;
	localparam int SEPI_DESEL_CYC = (SEPI_DESELECT_MIN_TIME_NS * SEPI_CLK_MHZ + 999) / 1000;
	// Self-timed programming, longest time in ms
	localparam int SEPI_PROG_MS = 15;
	localparam int SEPI_PROG_CYC = SEPI_PROG_MS * SEPI_CLK_MHZ * 1000;
	localparam int SEPI_TMR_W = 8;
	localparam int SEPI_PROG_W = 22;
	// Frame layout
	localparam int SEPI_ADDR_W = 6;
	localparam int SEPI_DATA_W = 16;
	localparam int SEPI_WORDS = 64;
	localparam int SEPI_HDR_BITS = 9;
	localparam int SEPI_FRAME_BITS = 25;
	// Opcodes and sub-codes in the two top address bits
	localparam logic [1:0] SEPI_OP_MISC = 2'h0;
	localparam logic [1:0] SEPI_OP_WRITE = 2'h1;
	localparam logic [1:0] SEPI_OP_READ = 2'h2;
	localparam logic [1:0] SEPI_OP_CLEAR = 2'h3;
	localparam logic [1:0] SEPI_SUB_OFF = 2'h0;
	localparam logic [1:0] SEPI_SUB_ALL = 2'h1;
	localparam logic [1:0] SEPI_SUB_ON = 2'h3;
	localparam logic [5:0] SEPI_ADDR_ONES = 6'h3F;
	localparam logic [5:0] SEPI_ADDR_ZERO = 6'h00;
	// Controller register offsets
	localparam logic [3:0] SEPI_REG_CMD = 4'h0;
	localparam logic [3:0] SEPI_REG_WDATA = 4'h1;
	localparam logic [3:0] SEPI_REG_STATUS = 4'h2;
	localparam logic [3:0] SEPI_REG_RDATA = 4'h3;
	// Command register fields
	localparam int SEPI_CMD_ADDR_LSB = 0;
	localparam int SEPI_CMD_OP_LSB = 6;
	localparam int SEPI_CMD_PRE_BIT = 8;
	localparam int SEPI_CMD_PE_BIT = 9;
	localparam int SEPI_CMD_CNT_LSB = 10;
	localparam int SEPI_CMD_CNT_W = 6;
	// Reset values
	localparam logic [15:0] SEPI_RST_WORD = 16'h0000;
	localparam logic [5:0] SEPI_RST_PROT_ADDR = 6'h00;
	// Device command states
	typedef enum logic [2:0] {
		SEPI_D_IDLE = 3'b000,
		SEPI_D_HDR = 3'b001,
		SEPI_D_DATA = 3'b010,
		SEPI_D_READ = 3'b011,
		SEPI_D_DONE = 3'b100
	} sepi_dev_state_t;
	// Pending actions launched on select fall
	typedef enum logic [2:0] {
		SEPI_A_NONE = 3'b000,
		SEPI_A_WEN = 3'b001,
		SEPI_A_WDS = 3'b010,
		SEPI_A_WR = 3'b011,
		SEPI_A_WRALL = 3'b100,
		SEPI_A_PREN = 3'b101,
		SEPI_A_PRWR = 3'b110,
		SEPI_A_PRCLR = 3'b111
	} sepi_act_t;
	// Controller states
	typedef enum logic [2:0] {
		SEPI_H_IDLE = 3'b000,
		SEPI_H_DESEL = 3'b001,
		SEPI_H_LOW = 3'b010,
		SEPI_H_HIGH = 3'b011,
		SEPI_H_WAITQ = 3'b100
	} sepi_host_state_t;
endpackage

// [logic/sepi_link_if.sv]
// Pin bundle between the serial EEPROM and its bus master
`timescale 1ns/1ps
interface sepi_link_if;
	logic devSelect;
	logic serial_clock;
	logic serial_in;
	logic protSel;
	logic write_permit;
	logic serialOut;
	logic serialOutEn;
	// Level the master sees; undriven output reads low here
	logic serialOutWire;
	assign serialOutWire = serialOutEn & serialOut;
	modport dev (input devSelect, input serial_clock, input serial_in, input protSel,
		input write_permit, output serialOut, output serialOutEn);
	modport host (output devSelect, output serial_clock, output serial_in, output protSel,
		output write_permit, input serialOutWire);
endinterface

// [logic/sepi_host_ctrl.sv]
// Bus master end: register port, serial clock divider and a two-word read buffer
`timescale 1ns/1ps
module sepi_host_ctrl (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	sepi_link_if.host link
);
	import sepi_pkg::*;

	sepi_host_state_t state_q, state_d;
	logic [SEPI_TMR_W-1:0] tmr_q, tmr_d;
	logic [24:0] tx_q, tx_d;
	logic [4:0] txLeft_q, txLeft_d;
	logic [15:0] rx_q, rx_d;
	logic [3:0] rxCnt_q, rxCnt_d;
	logic rxOn_q, rxOn_d;
	logic [5:0] words_q, words_d;
	logic [15:0] wdata_q, wdata_d;
	logic sel_q, sel_d;
	logic sk_q, sk_d;
	logic sdi_q, sdi_d;
	logic pre_q, pre_d;
	logic pe_q, pe_d;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] fifo_q [2];
	logic [15:0] fifoWord;
	logic wrPtr_q, wrPtr_d;
	logic rdPtr_q, rdPtr_d;
	logic [1:0] count_q, count_d;
	logic doMeta_q, doSync_q;
	logic push;
	logic pop;
	logic inReady;
	logic [1:0] op;
	logic [5:0] adr;
	logic longFrame;

	// Device output crosses in through two flip-flops
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			doMeta_q <= 1'b0;
			doSync_q <= 1'b0;
		end else if (clkEn) begin
			doMeta_q <= link.serialOutWire;
			doSync_q <= doMeta_q;
		end
	end

	assign op = regWdata[SEPI_CMD_OP_LSB +: 2];
	assign adr = regWdata[SEPI_CMD_ADDR_LSB +: SEPI_ADDR_W];
	// Word writes carry sixteen data bits behind the header
	assign longFrame = !regWdata[SEPI_CMD_PRE_BIT] && (op == SEPI_OP_WRITE ||
		(op == SEPI_OP_MISC && adr[5:4] == SEPI_SUB_ALL));
	// Buffer handshake: filled by the serial engine, drained by register reads
	assign inReady = (count_q != 2'd2);
	assign push = (state_q == SEPI_H_WAITQ) && inReady;
	assign pop = regRd && regAddr == SEPI_REG_RDATA && count_q != 2'd0;
	assign fifoWord = fifo_q[rdPtr_q];

	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		tx_d = tx_q;
		txLeft_d = txLeft_q;
		rx_d = rx_q;
		rxCnt_d = rxCnt_q;
		rxOn_d = rxOn_q;
		words_d = words_q;
		wdata_d = wdata_q;
		sel_d = sel_q;
		sk_d = sk_q;
		sdi_d = sdi_q;
		pre_d = pre_q;
		pe_d = pe_q;
		wrPtr_d = wrPtr_q ^ push;
		rdPtr_d = rdPtr_q ^ pop;
		count_d = count_q + {1'b0, push} - {1'b0, pop};
		rdata_d = 16'h0000;
		if (regRd) begin
			case (regAddr)
				SEPI_REG_WDATA: rdata_d = wdata_q;
				SEPI_REG_STATUS: rdata_d = {13'h0000, count_q, state_q != SEPI_H_IDLE};
				SEPI_REG_RDATA: rdata_d = fifoWord;
				default: rdata_d = 16'h0000;
			endcase
		end
		if (regWr && regAddr == SEPI_REG_WDATA) begin
			wdata_d = regWdata;
		end
		if (tmr_q != '0) begin
			tmr_d = tmr_q - 1'b1;
		end
		case (state_q)
			SEPI_H_IDLE: begin
				if (regWr && regAddr == SEPI_REG_CMD) begin
					// Mode pins set before select and held all cycle
					tx_d = {1'b1, op, adr, wdata_q};
					txLeft_d = longFrame ? 5'(SEPI_FRAME_BITS) : 5'(SEPI_HDR_BITS);
					rxOn_d = (op == SEPI_OP_READ);
					words_d = regWdata[SEPI_CMD_CNT_LSB +: SEPI_CMD_CNT_W];
					pre_d = regWdata[SEPI_CMD_PRE_BIT];
					pe_d = regWdata[SEPI_CMD_PE_BIT];
					sel_d = 1'b0;
					tmr_d = SEPI_TMR_W'(SEPI_DESEL_CYC);
					state_d = SEPI_H_DESEL;
				end
			end
			SEPI_H_DESEL: begin
				if (tmr_q == '0) begin
					sel_d = 1'b1;
					sdi_d = tx_q[24];
					tmr_d = SEPI_TMR_W'(SEPI_SK_HALF_CYC);
					state_d = SEPI_H_LOW;
				end
			end
			SEPI_H_LOW: begin
				if (tmr_q == '0) begin
					sk_d = 1'b1;
					tmr_d = SEPI_TMR_W'(SEPI_SK_HALF_CYC);
					state_d = SEPI_H_HIGH;
				end
			end
			SEPI_H_HIGH: begin
				if (tmr_q == '0) begin
					// Sample late in the high phase, far from the launching rise
					sk_d = 1'b0;
					tmr_d = SEPI_TMR_W'(SEPI_SK_HALF_CYC);
					state_d = SEPI_H_LOW;
					if (txLeft_q != 5'h00) begin
						txLeft_d = txLeft_q - 1'b1;
						tx_d = {tx_q[23:0], 1'b0};
						sdi_d = tx_q[23];
						rxCnt_d = 4'h0;
						if (txLeft_q == 5'h01 && !rxOn_q) begin
							sel_d = 1'b0;
							state_d = SEPI_H_IDLE;
						end
					end else begin
						rx_d = {rx_q[14:0], doSync_q};
						rxCnt_d = rxCnt_q + 1'b1;
						if (rxCnt_q == 4'hF) begin
							state_d = SEPI_H_WAITQ;
						end
					end
				end
			end
			SEPI_H_WAITQ: begin
				// Clock stays low while the buffer is full
				if (push) begin
					tmr_d = SEPI_TMR_W'(SEPI_SK_HALF_CYC);
					if (words_q == 6'h00) begin
						sel_d = 1'b0;
						state_d = SEPI_H_IDLE;
					end else begin
						words_d = words_q - 1'b1;
						state_d = SEPI_H_LOW;
					end
				end
			end
			default: state_d = SEPI_H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= SEPI_H_IDLE;
			tmr_q <= '0;
			tx_q <= 25'h0000000;
			txLeft_q <= 5'h00;
			rx_q <= SEPI_RST_WORD;
			rxCnt_q <= 4'h0;
			rxOn_q <= 1'b0;
			words_q <= 6'h00;
			wdata_q <= SEPI_RST_WORD;
			sel_q <= 1'b0;
			sk_q <= 1'b0;
			sdi_q <= 1'b0;
			pre_q <= 1'b0;
			pe_q <= 1'b0;
			rdata_q <= SEPI_RST_WORD;
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			count_q <= 2'h0;
			fifo_q[0] <= SEPI_RST_WORD;
			fifo_q[1] <= SEPI_RST_WORD;
		end else if (clkEn) begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			tx_q <= tx_d;
			txLeft_q <= txLeft_d;
			rx_q <= rx_d;
			rxCnt_q <= rxCnt_d;
			rxOn_q <= rxOn_d;
			words_q <= words_d;
			wdata_q <= wdata_d;
			sel_q <= sel_d;
			sk_q <= sk_d;
			sdi_q <= sdi_d;
			pre_q <= pre_d;
			pe_q <= pe_d;
			rdata_q <= rdata_d;
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			if (push) begin
				fifo_q[wrPtr_q] <= rx_q;
			end
		end
	end

	assign regRdata = rdata_q;
	assign link.devSelect = sel_q;
	assign link.serial_clock = sk_q;
	assign link.serial_in = sdi_q;
	assign link.protSel = pre_q;
	assign link.write_permit = pe_q;
endmodule // sepi_host_ctrl

// [sim/sepi_link_chk.sv]
// Concurrent checks on the pins between the host controller and the EEPROM device
`timescale 1ns/1ps
module sepi_link_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic devSelect,
	input wire logic serial_clock,
	input wire logic serial_in,
	input wire logic protSel,
	input wire logic write_permit,
	input wire logic serialOut,
	input wire logic serialOutEn,
	input wire logic progBusy
);
	import sepi_pkg::*;
	int phaseCnt_q;
	int phaseCnt_d;
	int lowCnt_q;
	int lowCnt_d;
	logic skPrev_q;
	logic skPrev_d;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Cycle counts since the link clock last moved and since select went low; saturate to stay small
	always_comb begin
		skPrev_d = serial_clock;
		phaseCnt_d = (serial_clock != skPrev_q) ? 0 : ((phaseCnt_q < 1000) ? phaseCnt_q + 1 : 1000);
		lowCnt_d = devSelect ? 0 : ((lowCnt_q < 1000) ? lowCnt_q + 1 : 1000);
	end

	// Counter registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			skPrev_q <= 1'b0;
			phaseCnt_q <= 0;
			lowCnt_q <= 0;
		end else begin
			skPrev_q <= skPrev_d;
			phaseCnt_q <= phaseCnt_d;
			lowCnt_q <= lowCnt_d;
		end
	end

	a_out_desel: assert property (!devSelect [*5] |-> !serialOutEn)
		else $error("serial output driven while deselected");
	a_out_edge: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut) |->
		serial_clock && phaseCnt_q <= 6) else $error("serial output moved away from clock rise");
	a_clk_idle: assert property (!devSelect |-> !serial_clock)
		else $error("link clock high while deselected");
	a_desel_min: assert property ($rose(devSelect) |-> lowCnt_q >= SEPI_DESEL_CYC)
		else $error("select low time too short");
	a_clk_half: assert property (devSelect && $past(devSelect) && $changed(serial_clock) |->
		phaseCnt_q >= SEPI_SK_HALF_CYC - 1) else $error("link clock phase too short");
	a_din_stable: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_in))
		else $error("serial input moved while clock high");
	a_mode_stable: assert property (devSelect && $past(devSelect) |->
		$stable(protSel) && $stable(write_permit)) else $error("mode pins moved in a cycle");
	a_start_bit: assert property ($rose(devSelect) |-> serial_in)
		else $error("frame did not open with a one");
	// Launch waits for the synced select fall; ten cycles covers the sync stages
	a_prog_launch: assert property ($rose(progBusy) |-> !devSelect && lowCnt_q <= 10)
		else $error("programming began without a select fall");
endmodule // sepi_link_chk

// [sim/sepi_tb.sv]
// Self-checking bench: host controller drives the EEPROM device over the pin link
`timescale 1ns/1ps
module sepi_tb;
	import sepi_pkg::*;
	// Short programming time keeps the run brief
	localparam int PROG_SIM = 50;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic progBusy;
	logic write_lock_state;
	logic [15:0] rd;
	int bad_count = 0;
	int tests_run = 0;
	int busyRises = 0;

	sepi_link_if sepi_link_if_i ();
	sepi_host_ctrl sepi_host_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .link(sepi_link_if_i.host));
	sepi_eeprom_dev #(.PROG_CYC(PROG_SIM)) sepi_eeprom_dev_i (.ref_clk(ref_clk), .nrst(nrst),
		.clkEn(1'b1), .link(sepi_link_if_i.dev), .progBusy(progBusy),
		.write_lock_state(write_lock_state));
	sepi_link_chk sepi_link_chk_i (.ref_clk(ref_clk), .nrst(nrst),
		.devSelect(sepi_link_if_i.devSelect), .serial_clock(sepi_link_if_i.serial_clock),
		.serial_in(sepi_link_if_i.serial_in), .protSel(sepi_link_if_i.protSel),
		.write_permit(sepi_link_if_i.write_permit), .serialOut(sepi_link_if_i.serialOut),
		.serialOutEn(sepi_link_if_i.serialOutEn), .progBusy(progBusy));

	// 200 MHz reference clock
	always #2.5 ref_clk = ~ref_clk;

	// Count launches, so a refused write shows as a missing pulse
	always @(posedge progBusy) busyRises++;

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask

	// Poll status until the frame is over, then let programming finish
	task automatic wait_idle();
		int n;
		logic [15:0] s;
		n = 0;
		do begin
			reg_rd(SEPI_REG_STATUS, s);
			n++;
		end while (s[0] !== 1'b0 && n < 20000);
		if (n >= 20000) chk("idle wait", 16'h0000, s);
		repeat (PROG_SIM + 20) @(posedge ref_clk);
	endtask

	task automatic run_cmd(input logic [1:0] op, input logic [5:0] a, input logic pre,
		input logic pe, input logic [5:0] cnt, input logic [15:0] wd);
		reg_wr(SEPI_REG_WDATA, wd);
		reg_wr(SEPI_REG_CMD, {cnt, pe, pre, op, a});
		wait_idle();
	endtask

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("lock at reset", 16'h0001, {15'h0, write_lock_state});
		chk("select at reset", 16'h0000, {15'h0, sepi_link_if_i.devSelect});
		reg_rd(SEPI_REG_STATUS, rd);
		chk("status at reset", 16'h0000, rd);
		run_cmd(SEPI_OP_WRITE, SEPI_ADDR_ONES, 1'b0, 1'b1, 6'h00, 16'h1234);
		chk("write while locked", 16'h0000, 16'(busyRises));
		run_cmd(SEPI_OP_MISC, {SEPI_SUB_ON, 4'h0}, 1'b0, 1'b1, 6'h00, 16'h0000);
		chk("lock after enable", 16'h0000, {15'h0, write_lock_state});
		run_cmd(SEPI_OP_WRITE, SEPI_ADDR_ONES, 1'b0, 1'b1, 6'h00, 16'hA5C3);
		chk("write launch", 16'h0001, 16'(busyRises));
		run_cmd(SEPI_OP_WRITE, SEPI_ADDR_ONES, 1'b0, 1'b0, 6'h00, 16'h5A3C);
		chk("write without permit", 16'h0001, 16'(busyRises));
		run_cmd(SEPI_OP_WRITE, SEPI_ADDR_ZERO, 1'b0, 1'b1, 6'h00, 16'h8001);
		// Two words from the top location wrap round to location zero
		run_cmd(SEPI_OP_READ, SEPI_ADDR_ONES, 1'b0, 1'b0, 6'h01, 16'h0000);
		reg_rd(SEPI_REG_STATUS, rd);
		chk("buffer full", 16'h0004, rd);
		reg_rd(SEPI_REG_RDATA, rd);
		chk("first word", 16'hA5C3, rd);
		reg_rd(SEPI_REG_RDATA, rd);
		chk("wrapped word", 16'h8001, rd);
		reg_rd(SEPI_REG_STATUS, rd);
		chk("buffer empty", 16'h0000, rd);
		run_cmd(SEPI_OP_MISC, {SEPI_SUB_OFF, 4'h0}, 1'b0, 1'b0, 6'h00, 16'h0000);
		chk("lock after disable", 16'h0001, {15'h0, write_lock_state});
		run_cmd(SEPI_OP_WRITE, SEPI_ADDR_ZERO, 1'b0, 1'b1, 6'h00, 16'h7E7E);
		chk("write after disable", 16'h0002, 16'(busyRises));
		run_cmd(SEPI_OP_READ, SEPI_ADDR_ZERO, 1'b0, 1'b0, 6'h00, 16'h0000);
		reg_rd(SEPI_REG_RDATA, rd);
		chk("word kept", 16'h8001, rd);
		run_cmd(SEPI_OP_READ, SEPI_ADDR_ZERO, 1'b1, 1'b0, 6'h00, 16'h0000);
		reg_rd(SEPI_REG_RDATA, rd);
		chk("protect read", {10'h000, SEPI_RST_PROT_ADDR}, rd);
		reg_wr(4'hC, 16'hFFFF);
		reg_rd(4'hC, rd);
		chk("unmapped", 16'h0000, rd);
		print_verdict();
	end

	// Watchdog a little beyond the expected run of about half a millisecond
	initial begin
		#550000;
		bad_count++;
		$display("[ERR] run time expected finish seen timeout");
		print_verdict();
	end
endmodule // sepi_tb
